//--- rtl/tlic_pkg.sv
// Package of constants and carrier types for the line interface control block
package tlic_pkg;
    localparam int CLK_MHZ = 100;
    // Bus map
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] FIFO_OFS = 8'h08;
    localparam logic [7:0] PULSE_OFS = 8'h0C;
    // Control register fields
    localparam int CTRL_CFG_LSB = 0;
    localparam int CTRL_AOS_BIT = 3;
    localparam int CTRL_LOCAL_LOOP_SELECT_BIT = 4;
    localparam int CTRL_REMOTE_LOOP_SELECT_BIT = 5;
    localparam int CTRL_EDGE_BIT = 6;
    localparam int CTRL_RATE_BIT = 7;
    localparam int CTRL_RST_BIT = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // Pulse widths and slicing levels
    localparam int E1_PULSE_NS = 244;
    localparam int OPTA_PULSE_NS = 324;
    localparam int DSX_PULSE_NS = 350;
    localparam logic [6:0] SLICE_T1_PCT = 7'd65;
    localparam logic [6:0] SLICE_E1_PCT = 7'd50;
    // Timing
    localparam int SETTLE_BITS = 22;
    localparam int POWER_WAIT_MS = 10;
    localparam int CAL_MAX_MS = 20;
    localparam int POWER_WAIT_CYC = POWER_WAIT_MS * 1000 * CLK_MHZ;
    localparam int CAL_CYC = CAL_MAX_MS * 1000 * CLK_MHZ / 2;
    localparam int DPM_IDLE_REF = 512;
    localparam int LOS_ZEROS = 175;
    localparam int CLR_WINDOW = 175;
    localparam int CLR_MIN_ONES = 22;
    localparam int CLR_MAX_ZEROS = 100;
    localparam int TXCLK_DEAD_REF = 4;
    localparam int FIFO_DEPTH = 64;
    localparam int FIFO_TYP_UI = 43;
    localparam int FIFO_MIN_UI = 22;
    localparam int RECOVER_MARKS = 175;

    typedef struct packed {
        logic plus;
        logic minus;
    } tlic_bit_t;

    typedef struct packed {
        logic [2:0] cfg;
        logic aos;
        logic local_loop_select;
        logic remote_loop_select;
        logic edge_sel;
        logic rate8x;
    } tlic_ctrl_t;
endpackage : tlic_pkg

//--- rtl/tlic_sync.sv
// Three-stage pin synchroniser with agreement filter
module tlic_sync #(
    parameter int W = 1
) (
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            q_o <= '0;
        end else begin
            s1_reg <= d_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            // Change counts once stages two and three agree
            for (int i = 0; i < W; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    q_o[i] <= s3_reg[i];
                end
            end
        end
    end
endmodule : tlic_sync

//--- rtl/tlic_top.sv
// One channel of line interface control: tx path, jitter FIFO, rx, monitors
module tlic_top
    import tlic_pkg::*;
#(
    parameter int POWER_WAIT = tlic_pkg::POWER_WAIT_CYC,
    parameter int CAL_TIME = tlic_pkg::CAL_CYC,
    parameter int DEPTH = tlic_pkg::FIFO_DEPTH
) (
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    input wire logic TX_CLOCK_I,
    input wire logic TX_PLUS_DATA_I,
    input wire logic TX_MINUS_DATA_I,
    input wire logic REFERENCE_CLOCK_IN_I,
    input wire logic RX_LINE_P_I,
    input wire logic RX_LINE_N_I,
    input wire logic MONITOR_IN_P_I,
    input wire logic MONITOR_IN_N_I,
    output logic LINE_OUT_P_O,
    output logic LINE_OUT_N_O,
    output logic RX_CLOCK_O,
    output logic RX_PLUS_DATA_O,
    output logic RX_MINUS_DATA_O,
    output logic SIGNAL_LOSS_FLAG_O,
    output logic DRIVER_MONITOR_ALARM_O,
    output logic CAL_DONE_O
);
    import tlic_pkg::*;

    localparam int PW = $clog2(DEPTH);
    localparam int HALF = DEPTH / 2;
    localparam int MARGIN = HALF - FIFO_TYP_UI / 2;

    // Synchronised pins
    logic [6:0] pins;
    tlic_sync #(.W(7)) u_sync (
        .CLK_I(CLK_I),
        .ARST_N_I(ARST_N_I),
        .d_i({TX_CLOCK_I, TX_PLUS_DATA_I, TX_MINUS_DATA_I, REFERENCE_CLOCK_IN_I,
              RX_LINE_P_I, RX_LINE_N_I, MONITOR_IN_P_I ^ MONITOR_IN_N_I}),
        .q_o(pins)
    );
    logic tck_s, ref_s, mon_s;
    tlic_bit_t txd_s, rxl_s;
    assign tck_s = pins[6];
    assign txd_s = pins[5:4];
    assign ref_s = pins[3];
    assign rxl_s = pins[2:1];
    assign mon_s = pins[0];

    logic tck_d_reg, ref_d_reg;
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            tck_d_reg <= 1'b0;
            ref_d_reg <= 1'b0;
        end else begin
            tck_d_reg <= tck_s;
            ref_d_reg <= ref_s;
        end
    end
    logic tck_fall, ref_rise;
    assign tck_fall = tck_d_reg & ~tck_s;
    assign ref_rise = ref_s & ~ref_d_reg;

    // Control register
    tlic_ctrl_t ctrl_reg;
    logic rst_req;
    logic [2:0] ref_div_reg;
    logic line_tick;
    // 8X reference is divided down to one line-bit tick
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ref_div_reg <= 3'h0;
        end else if (ref_rise) begin
            ref_div_reg <= ref_div_reg + 3'h1;
        end
    end
    assign line_tick = ref_rise & (!ctrl_reg.rate8x || ref_div_reg == 3'h7);

    // Power-up / reset sequencing
    typedef enum {S_WAIT, S_CAL, S_RUN} tlic_seq_t;
    tlic_seq_t seq_reg;
    logic [31:0] seq_cnt_reg;
    logic [2:0] tdead_reg;
    logic tck_alive;
    assign tck_alive = tdead_reg < 3'(TXCLK_DEAD_REF);
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            seq_reg <= S_WAIT;
            seq_cnt_reg <= 32'h0000_0000;
        end else if (rst_req) begin
            seq_reg <= S_WAIT;
            seq_cnt_reg <= 32'h0000_0000;
        end else begin
            unique case (seq_reg)
                S_WAIT: begin
                    seq_cnt_reg <= seq_cnt_reg + 32'h0000_0001;
                    if (seq_cnt_reg >= 32'(POWER_WAIT - 1)) begin
                        seq_reg <= S_CAL;
                        seq_cnt_reg <= 32'h0000_0000;
                    end
                end
                S_CAL: begin
                    // Calibration only advances with both clocks present
                    if (ref_rise && tck_alive) begin
                        seq_cnt_reg <= seq_cnt_reg + 32'h0000_0001;
                    end
                    if (seq_cnt_reg >= 32'(CAL_TIME / 100)) begin
                        seq_reg <= S_RUN;
                    end
                end
                S_RUN: begin
                    seq_reg <= S_RUN;
                end
            endcase
        end
    end
    logic run;
    assign run = seq_reg == S_RUN;

    // Tx clock inactivity
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            tdead_reg <= 3'(TXCLK_DEAD_REF);
        end else if (tck_fall) begin
            tdead_reg <= 3'h0;
        end else if (ref_rise && tck_alive) begin
            tdead_reg <= tdead_reg + 3'h1;
        end
    end

    // Rx recovery: each line tick is one bit; marks are line pulses
    logic rx_mark, rx_mark_reg;
    tlic_bit_t rx_bit_reg;
    logic [7:0] zrun_reg;
    logic los_reg;
    logic [7:0] win_cnt_reg, win_ones_reg;
    assign rx_mark = rxl_s.plus | rxl_s.minus;
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rx_mark_reg <= 1'b0;
            rx_bit_reg <= '0;
        end else if (line_tick) begin
            rx_bit_reg <= '0;
            rx_mark_reg <= 1'b0;
        end else if (rx_mark) begin
            rx_bit_reg <= rxl_s;
            rx_mark_reg <= 1'b1;
        end
    end
    // Loss and recovery share a zero-run and density monitor
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            zrun_reg <= 8'h00;
            los_reg <= 1'b1;
            win_cnt_reg <= 8'h00;
            win_ones_reg <= 8'h00;
        end else if (!run) begin
            los_reg <= 1'b1;
            zrun_reg <= 8'h00;
            win_cnt_reg <= 8'h00;
            win_ones_reg <= 8'h00;
        end else if (line_tick) begin
            zrun_reg <= rx_mark_reg ? 8'h00 : (zrun_reg == 8'hFF ? zrun_reg : zrun_reg + 8'h01);
            if (!rx_mark_reg && zrun_reg >= 8'(LOS_ZEROS - 1)) begin
                los_reg <= 1'b1;
            end
            if (los_reg) begin
                if (!rx_mark_reg && zrun_reg >= 8'(CLR_MAX_ZEROS)) begin
                    win_cnt_reg <= 8'h00;
                    win_ones_reg <= 8'h00;
                end else if (win_cnt_reg == 8'(CLR_WINDOW - 1)) begin
                    los_reg <= (win_ones_reg + 8'(rx_mark_reg)) < 8'(CLR_MIN_ONES);
                    win_cnt_reg <= 8'h00;
                    win_ones_reg <= 8'h00;
                end else begin
                    win_cnt_reg <= win_cnt_reg + 8'h01;
                    win_ones_reg <= win_ones_reg + 8'(rx_mark_reg);
                end
            end
        end
    end

    // Jitter FIFO: written on tx clock (on line tick in remote loop), read on smoothed line tick
    logic [DEPTH-1:0] fifo_p_reg, fifo_n_reg;
    logic [PW:0] wptr_reg, rptr_reg;
    logic [PW:0] fill;
    logic locked_reg;
    logic [3:0] bias_reg;
    assign fill = wptr_reg - rptr_reg;
    tlic_bit_t wr_bit;
    logic wr_en;
    // Remote loop feeds recovered data, local timing from the rx tick
    assign wr_en = ctrl_reg.remote_loop_select ? line_tick : tck_fall;
    assign wr_bit = ctrl_reg.remote_loop_select ? rx_bit_reg : txd_s;
    logic near_full, near_empty, rd_en;
    // Before lock the guard band is narrower so the minimum span still holds
    assign near_full = fill >= (PW+1)'(locked_reg ? DEPTH - MARGIN : HALF + FIFO_MIN_UI);
    assign near_empty = fill <= (PW+1)'(locked_reg ? MARGIN : HALF - FIFO_MIN_UI);
    // Read on the smoothed tick; near full reads track writes, near empty reads stop
    assign rd_en = near_full ? wr_en : (near_empty ? 1'b0 : line_tick);
    generate
        for (genvar i = 0; i < DEPTH; i++) begin : g_fifo
            always_ff @(posedge CLK_I or negedge ARST_N_I) begin
                if (!ARST_N_I) begin
                    fifo_p_reg[i] <= 1'b0;
                    fifo_n_reg[i] <= 1'b0;
                end else if (wr_en && wptr_reg[PW-1:0] == PW'(i)) begin
                    fifo_p_reg[i] <= wr_bit.plus;
                    fifo_n_reg[i] <= wr_bit.minus;
                end
            end
        end
    endgenerate
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            wptr_reg <= (PW+1)'(HALF);
            rptr_reg <= '0;
            locked_reg <= 1'b0;
            bias_reg <= 4'h0;
        end else if (!run) begin
            wptr_reg <= (PW+1)'(HALF);
            rptr_reg <= '0;
            locked_reg <= 1'b0;
            bias_reg <= 4'h0;
        end else begin
            if (wr_en) begin
                wptr_reg <= wptr_reg + 1'b1;
            end
            if (rd_en) begin
                rptr_reg <= rptr_reg + 1'b1;
            end
            // Lock declared after 16 line ticks without guard action; guard ticks only pause the count
            if (line_tick && !near_full && !near_empty && !locked_reg) begin
                bias_reg <= bias_reg + 4'h1;
                locked_reg <= bias_reg == 4'hF;
            end
        end
    end
    // Gaps of up to 22 UI sit inside the half-depth preload
    tlic_bit_t rd_bit;
    assign rd_bit = '{plus: fifo_p_reg[rptr_reg[PW-1:0]], minus: fifo_n_reg[rptr_reg[PW-1:0]]};

    // Tx line driver with pulse width from config
    logic [5:0] pw_cnt_reg;
    logic [5:0] pw_cyc;
    logic aos_phase_reg;
    tlic_bit_t drv_reg;
    always_comb begin
        unique case (ctrl_reg.cfg)
            3'b000, 3'b001: pw_cyc = 6'((E1_PULSE_NS * CLK_MHZ) / 1000);
            3'b010: pw_cyc = 6'((OPTA_PULSE_NS * CLK_MHZ) / 1000);
            default: pw_cyc = 6'((DSX_PULSE_NS * CLK_MHZ) / 1000);
        endcase
    end
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            pw_cnt_reg <= 6'h00;
            drv_reg <= '0;
            aos_phase_reg <= 1'b0;
        end else if (!run) begin
            pw_cnt_reg <= 6'h00;
            drv_reg <= '0;
        end else if (line_tick) begin
            pw_cnt_reg <= pw_cyc;
            if (ctrl_reg.aos) begin
                // All ones: alternate marks at line tick rate
                aos_phase_reg <= ~aos_phase_reg;
                drv_reg <= aos_phase_reg ? 2'b01 : 2'b10;
            end else if (!tck_alive && !ctrl_reg.remote_loop_select) begin
                drv_reg <= '0;
            end else begin
                // Changes take effect from the next bit, well inside 22 bits
                drv_reg <= rd_bit;
            end
        end else if (pw_cnt_reg != 6'h00) begin
            pw_cnt_reg <= pw_cnt_reg - 6'h01;
        end else begin
            drv_reg <= '0;
        end
    end

    // Rx outputs; local loop returns FIFO data, else recovered data
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            RX_CLOCK_O <= 1'b0;
            RX_PLUS_DATA_O <= 1'b0;
            RX_MINUS_DATA_O <= 1'b0;
        end else if (line_tick) begin
            // Signal loss leaves the output at line tick rate
            RX_CLOCK_O <= ctrl_reg.edge_sel;
            RX_PLUS_DATA_O <= ctrl_reg.local_loop_select ? rd_bit.plus : rx_bit_reg.plus;
            RX_MINUS_DATA_O <= ctrl_reg.local_loop_select ? rd_bit.minus : rx_bit_reg.minus;
        end else if (ref_s != ref_d_reg && !ref_s) begin
            RX_CLOCK_O <= ~ctrl_reg.edge_sel;
        end
    end

    // Driver performance monitor
    logic [9:0] idle_reg;
    logic mon_d_reg, mon_mark_reg;
    logic [7:0] mz_reg, mcnt_reg, mones_reg;
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            mon_d_reg <= 1'b0;
            mon_mark_reg <= 1'b0;
            idle_reg <= 10'h000;
            mz_reg <= 8'h00;
            mcnt_reg <= 8'h00;
            mones_reg <= 8'h00;
            DRIVER_MONITOR_ALARM_O <= 1'b0;
        end else begin
            mon_d_reg <= mon_s;
            if (mon_s && !mon_d_reg) begin
                mon_mark_reg <= 1'b1;
            end
            if (line_tick) begin
                // A mark arriving on the tick itself is kept, not lost
                mon_mark_reg <= mon_s && !mon_d_reg;
                if (mon_mark_reg) begin
                    idle_reg <= 10'h000;
                end else if (idle_reg < 10'(DPM_IDLE_REF - 1)) begin
                    idle_reg <= idle_reg + 10'h001;
                end else begin
                    DRIVER_MONITOR_ALARM_O <= 1'b1;
                end
                mz_reg <= mon_mark_reg ? 8'h00 : (mz_reg == 8'hFF ? mz_reg : mz_reg + 8'h01);
                if (!mon_mark_reg && mz_reg >= 8'(CLR_MAX_ZEROS)) begin
                    mcnt_reg <= 8'h00;
                    mones_reg <= 8'h00;
                end else if (mcnt_reg == 8'(CLR_WINDOW - 1)) begin
                    if ((mones_reg + 8'(mon_mark_reg)) >= 8'(CLR_MIN_ONES)) begin
                        DRIVER_MONITOR_ALARM_O <= 1'b0;
                    end
                    mcnt_reg <= 8'h00;
                    mones_reg <= 8'h00;
                end else begin
                    mcnt_reg <= mcnt_reg + 8'h01;
                    mones_reg <= mones_reg + 8'(mon_mark_reg);
                end
            end
        end
    end

    // Registered pin outputs
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            LINE_OUT_P_O <= 1'b0;
            LINE_OUT_N_O <= 1'b0;
            SIGNAL_LOSS_FLAG_O <= 1'b1;
            CAL_DONE_O <= 1'b0;
        end else begin
            LINE_OUT_P_O <= drv_reg.plus;
            LINE_OUT_N_O <= drv_reg.minus;
            SIGNAL_LOSS_FLAG_O <= los_reg;
            CAL_DONE_O <= run;
        end
    end

    // AHB-Lite slave, zero wait states
    logic ph_valid_reg, ph_write_reg;
    logic [7:0] ph_addr_reg;
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ph_valid_reg <= 1'b0;
            ph_write_reg <= 1'b0;
            ph_addr_reg <= 8'h00;
        end else if (HREADY_I) begin
            ph_valid_reg <= HSEL_I & HTRANS_I[1];
            ph_write_reg <= HWRITE_I;
            ph_addr_reg <= HADDR_I[7:0];
        end
    end
    assign rst_req = ph_valid_reg && ph_write_reg && ph_addr_reg == CTRL_OFS && HWDATA_I[CTRL_RST_BIT];
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ctrl_reg <= tlic_ctrl_t'(CTRL_RESET[8:0]);
        end else if (ph_valid_reg && ph_write_reg && ph_addr_reg == CTRL_OFS) begin
            ctrl_reg <= '{cfg: HWDATA_I[CTRL_CFG_LSB +: 3], aos: HWDATA_I[CTRL_AOS_BIT],
                          local_loop_select: HWDATA_I[CTRL_LOCAL_LOOP_SELECT_BIT], remote_loop_select: HWDATA_I[CTRL_REMOTE_LOOP_SELECT_BIT],
                          edge_sel: HWDATA_I[CTRL_EDGE_BIT], rate8x: HWDATA_I[CTRL_RATE_BIT]};
        end
    end
    logic [6:0] slice_pct;
    assign slice_pct = (ctrl_reg.cfg[2:1] == 2'b00) ? SLICE_E1_PCT : SLICE_T1_PCT;
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            HRDATA_O <= 32'h0000_0000;
            HREADYOUT_O <= 1'b1;
            HRESP_O <= 1'b0;
        end else if (HREADY_I && HSEL_I && HTRANS_I[1] && !HWRITE_I) begin
            unique case (HADDR_I[7:0])
                CTRL_OFS: HRDATA_O <= {24'h00_0000, ctrl_reg.rate8x, ctrl_reg.edge_sel,
                                       ctrl_reg.remote_loop_select, ctrl_reg.local_loop_select, ctrl_reg.aos, ctrl_reg.cfg};
                STAT_OFS: HRDATA_O <= {26'h000_0000, locked_reg, tck_alive, run,
                                       DRIVER_MONITOR_ALARM_O, los_reg, near_full | near_empty};
                FIFO_OFS: HRDATA_O <= {25'h000_0000, 7'(fill)};
                PULSE_OFS: HRDATA_O <= {17'h0_0000, slice_pct, 2'b00, pw_cyc};
                default: HRDATA_O <= 32'h0000_0000;
            endcase
        end
    end
endmodule : tlic_top

//--- verif/tlic_monitor.sv
// Port checker of the line interface control block
module tlic_monitor
    import tlic_pkg::*;
#(
    parameter int POWER_WAIT = 100
) (
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADYOUT_O,
    input wire logic HRESP_O,
    input wire logic TX_CLOCK_I,
    input wire logic REFERENCE_CLOCK_IN_I,
    input wire logic MONITOR_IN_P_I,
    input wire logic MONITOR_IN_N_I,
    input wire logic LINE_OUT_P_O,
    input wire logic LINE_OUT_N_O,
    input wire logic RX_CLOCK_O,
    input wire logic RX_PLUS_DATA_O,
    input wire logic RX_MINUS_DATA_O,
    input wire logic SIGNAL_LOSS_FLAG_O,
    input wire logic DRIVER_MONITOR_ALARM_O,
    input wire logic CAL_DONE_O
);
    timeunit 1ns;
    timeprecision 100ps;
    logic ctl_wr, ref_q, tck_q;
    logic [8:0] ctl;
    logic [15:0] idle_m, idle_t, wait_c;
    // Idle counters run on reference edges so limits match the device's own time base
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            {ctl_wr, ref_q, tck_q, ctl, idle_m, idle_t, wait_c} <= '0;
        end else begin
            ctl_wr <= HSEL_I && HTRANS_I[1] && HWRITE_I && HADDR_I[7:0] == CTRL_OFS;
            ctl <= ctl_wr ? HWDATA_I[8:0] : ctl;
            ref_q <= REFERENCE_CLOCK_IN_I;
            tck_q <= TX_CLOCK_I;
            idle_m <= (MONITOR_IN_P_I ^ MONITOR_IN_N_I) ? '0 : idle_m + 16'(REFERENCE_CLOCK_IN_I & ~ref_q);
            idle_t <= (TX_CLOCK_I != tck_q) ? '0 : idle_t + 16'(REFERENCE_CLOCK_IN_I & ~ref_q);
            wait_c <= CAL_DONE_O ? '0 : wait_c + 16'h0001;
        end
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!ARST_N_I);
    a_ready_high: assert property (HREADYOUT_O) else $error("hreadyout low");
    a_resp_okay: assert property (!HRESP_O) else $error("error response");
    a_los_calib: assert property (!CAL_DONE_O && !$past(CAL_DONE_O, 2) |-> SIGNAL_LOSS_FLAG_O)
        else $error("loss flag low before calibration done");
    a_cal_wait: assert property ($rose(CAL_DONE_O) |-> wait_c >= 16'(POWER_WAIT))
        else $error("calibration done too early");
    a_alarm_idle: assert property ($rose(DRIVER_MONITOR_ALARM_O) |-> idle_m >= 16'h01FE)
        else $error("alarm before 510 idle reference periods");
    a_dead_spaces: assert property (idle_t >= 16'h0008 && ($past(ctl, 200) & 9'h028) == 9'h000
        && (ctl & 9'h028) == 9'h000 |-> !LINE_OUT_P_O && !LINE_OUT_N_O) else $error("marks with tx clock dead");
    a_rx_rise_valid: assert property (!ctl[6] && $rose(RX_CLOCK_O) |-> $stable({RX_PLUS_DATA_O, RX_MINUS_DATA_O}))
        else $error("rx data moves at rising rx clock");
    a_rx_fall_valid: assert property (ctl[6] && $fell(RX_CLOCK_O) |-> $stable({RX_PLUS_DATA_O, RX_MINUS_DATA_O}))
        else $error("rx data moves at falling rx clock");
endmodule : tlic_monitor

bind tlic_top tlic_monitor #(.POWER_WAIT(POWER_WAIT)) u_tlic_monitor (.*);

//--- verif/tlic_framer_model.sv
// Framer model: gated 8 MHz tx clock carrying all-marks bipolar data
module tlic_framer_model (
    input wire logic run_i,
    output logic tx_clk_o,
    output logic tx_plus_o,
    output logic tx_minus_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        {tx_clk_o, tx_plus_o, tx_minus_o} = 3'h0;
        forever begin
            #62.5;
            if (run_i || tx_clk_o) begin // Parks low between bursts
                tx_clk_o = ~tx_clk_o;
            end
            if (tx_clk_o) begin // Launch on rising, stable over the falling sample
                {tx_plus_o, tx_minus_o} = {~tx_plus_o, tx_plus_o};
            end
        end
    end
endmodule : tlic_framer_model

//--- verif/test_tlic_top.sv
// Self-checking bench of the line interface control block
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin num_errors++; \
    $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module test_tlic_top;
    import tlic_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int REF_CYC = 49;
    logic clk, arst_n, hsel, hwrite, ref_clk, rx_p, rx_n, rx_on, mon_on, run, prev;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, rd;
    logic [31:0] hrdata;
    logic hready, tck, tp, tn, lp, ln, signal_loss_flag, alarm, cal;
    int num_errors, checked, n, cnt;
    tlic_top #(.POWER_WAIT(100), .CAL_TIME(400)) u_tlic_top (.CLK_I(clk), .ARST_N_I(arst_n), .HSEL_I(hsel),
        .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
        .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(), .TX_CLOCK_I(tck), .TX_PLUS_DATA_I(tp),
        .TX_MINUS_DATA_I(tn), .REFERENCE_CLOCK_IN_I(ref_clk), .RX_LINE_P_I(rx_p), .RX_LINE_N_I(rx_n),
        .MONITOR_IN_P_I(mon_on & lp), .MONITOR_IN_N_I(mon_on & ln), .LINE_OUT_P_O(lp), .LINE_OUT_N_O(ln),
        .RX_CLOCK_O(), .RX_PLUS_DATA_O(), .RX_MINUS_DATA_O(), .SIGNAL_LOSS_FLAG_O(signal_loss_flag),
        .DRIVER_MONITOR_ALARM_O(alarm), .CAL_DONE_O(cal));
    // Single channel, so one rate family throughout
    // Monitor loops this channel's own outputs, no second channel here
    tlic_framer_model u_tlic_framer_model (.run_i(run), .tx_clk_o(tck), .tx_plus_o(tp), .tx_minus_o(tn));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Own oscillator, not the tx clock, used as a 1X reference
    initial begin
        ref_clk = 1'b0;
        forever #(REF_CYC * 5) ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        {rx_p, rx_n} <= rx_on ? {~rx_p, rx_p} : 2'h0;
    end
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, wr, 24'h00_0000, a};
        do begin @(posedge clk); end while (hready !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        do begin @(posedge clk); end while (hready !== 1'b1);
        q = hrdata;
    endtask : ahb
    task automatic wait_for(ref logic s, input logic v, input int lim);
        n = 0;
        while (s !== v && n < lim) begin @(posedge clk); n++; end
    endtask : wait_for
    task automatic t_start;
        `CHK("los_powerup", 1'b1, signal_loss_flag)
        wait_for(cal, 1'b1, 5000);
        `CHK("cal_done", 1'b1, cal)
        `CHK("power_wait", 1'b1, n >= 100)
    endtask : t_start
    task automatic t_regs;
        ahb(1'b0, CTRL_OFS, 32'h0000_0000, rd);
        `CHK("ctrl_reset", CTRL_RESET, rd)
        ahb(1'b1, 8'h10, 32'hFFFF_FFFF, rd);
        ahb(1'b0, 8'h10, 32'h0000_0000, rd);
        `CHK("unmapped", 32'h0000_0000, rd)
        for (int c = 0; c < 8; c++) begin
            ahb(1'b1, CTRL_OFS, 32'(c), rd);
            ahb(1'b0, PULSE_OFS, 32'h0000_0000, rd);
            `CHK("pulse", 6'(((c < 2) ? E1_PULSE_NS : (c == 2) ? OPTA_PULSE_NS : DSX_PULSE_NS) / 10), rd[5:0])
            `CHK("slice", (c < 2) ? SLICE_E1_PCT : SLICE_T1_PCT, rd[14:8])
        end
    endtask : t_regs
    task automatic t_dead;
        run <= 1'b0;
        repeat (8 * REF_CYC) @(posedge clk);
        cnt = 0;
        repeat (500) begin @(posedge clk); if ((lp | ln) !== 1'b0) cnt++; end
        `CHK("dead_spaces", 0, cnt)
    endtask : t_dead
    task automatic t_alarm_aos;
        wait_for(alarm, 1'b1, 30000);
        `CHK("alarm_rise", 1'b1, alarm)
        ahb(1'b1, CTRL_OFS, 32'h0000_0008, rd);
        mon_on <= 1'b1;
        repeat (23 * REF_CYC) @(posedge clk);
        cnt = 0;
        repeat (100 * REF_CYC) begin
            @(posedge clk);
            if ((lp | ln) === 1'b1 && prev !== 1'b1) cnt++;
            prev = lp | ln;
        end
        `CHK("aos_marks", 1'b1, cnt >= 99 && cnt <= 101)
        wait_for(alarm, 1'b0, 260 * REF_CYC);
        `CHK("alarm_clear", 1'b0, alarm)
        ahb(1'b1, CTRL_OFS, 32'h0000_0000, rd);
        mon_on <= 1'b0;
    endtask : t_alarm_aos
    task automatic t_los;
        rx_on <= 1'b1;
        ahb(1'b1, CTRL_OFS, 32'h0000_0040, rd);
        wait_for(signal_loss_flag, 1'b0, 20000);
        `CHK("los_clear", 1'b0, signal_loss_flag)
        ahb(1'b1, CTRL_OFS, 32'h0000_0000, rd);
        repeat (2000) @(posedge clk);
        rx_on <= 1'b0;
        wait_for(signal_loss_flag, 1'b1, 190 * REF_CYC + 200);
        `CHK("los_rise", 1'b1, signal_loss_flag)
        `CHK("los_not_early", 1'b1, n >= 160 * REF_CYC)
    endtask : t_los
    task automatic t_rst;
        run <= 1'b1;
        ahb(1'b1, CTRL_OFS, 32'h0000_0100, rd);
        wait_for(cal, 1'b0, 20);
        `CHK("cal_restart", 1'b0, cal)
        t_start();
    endtask : t_rst
    task automatic close_out;
        if (num_errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out
    initial begin
        {arst_n, hsel, hwrite, htrans, haddr, hwdata, rx_on, mon_on, prev} = '0;
        {rx_p, rx_n} = 2'h0;
        run = 1'b1;
        {num_errors, checked} = '0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        t_start();
        t_regs();
        t_dead();
        t_alarm_aos();
        t_los();
        t_rst();
        close_out();
    end
    initial begin
        repeat (95000) @(posedge clk);
        num_errors++;
        close_out();
    end
endmodule : test_tlic_top
